// ### bench/ee_reader_model.sv
/*
 * Behavioural configuration eeprom reader: answers a word request after
 * a chosen number of cycles with a one-cycle ack.
 * Assumes the requester holds valid and addr until it sees the ack.
 */
`timescale 1ns/1ps
`default_nettype none

module ee_reader_model
    import media_pkg::*;
(
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // request and answer
    input  wire ee_request_type ee_request,
    output var  ee_answer_type  ee_answer,
    // stored word and answer latency
    input  wire logic [15:0]    word_19,
    input  wire logic [7:0]     ack_delay
);
    logic [7:0] wait_cnt;

    // data toggles outside the ack cycle so a stale capture shows up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt  <= 8'h00;
            ee_answer <= '{ack: 1'b0, data: 16'h5a5a};
        end
        else if (ee_answer.ack)
        begin
            ee_answer.ack  <= 1'b0;
            ee_answer.data <= ~ee_answer.data;
            wait_cnt       <= 8'h00;
        end
        else if (ee_request.valid && wait_cnt >= ack_delay)
        begin
            ee_answer.ack  <= 1'b1; // only word 19 holds the capability bits
            ee_answer.data <= (ee_request.addr == 8'h13) ? word_19 : ~word_19;
        end
        else
        begin
            wait_cnt       <= ee_request.valid ? wait_cnt + 8'h01 : 8'h00;
            ee_answer.data <= ~ee_answer.data;
        end
    end
endmodule

`default_nettype wire

// ### bench/media_capability_register_tb.sv
/*
 * Self-checking bench for the media capability register: reloads over
 * several resets with corner and random eeprom words, reads over APB.
 * Assumes the eeprom model in ee_reader_model.
 */
`timescale 1ns/1ps
`default_nettype none

module media_capability_register_tb;
    import media_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, load_done;
    logic [7:0] paddr, ack_delay;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] word_19, exp;
    logic err;
    ee_request_type ee_request;
    ee_answer_type ee_answer;
    media_bits_type media_capability;
    int err_total, tests_run;
    logic [31:0] seed;

    media_capability_register uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ee_request(ee_request), .ee_answer(ee_answer),
        .media_capability(media_capability), .load_done(load_done));

    ee_reader_model eeprom (.pclk(pclk), .presetn(presetn), .ee_request(ee_request),
        .ee_answer(ee_answer), .word_19(word_19), .ack_delay(ack_delay));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // reference: only the board bits survive, mii phy hides the internal tx bit
    function automatic logic [15:0] ref_media(input int w);
        int m;
        m = w & 'h4e;
        if (m & 'h40)
            m = m & ~'h2;
        return 16'(m);
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    // one apb transfer; holds everything until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the wait ends once pready is seen high; the watchdog only if it never is
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog sized well above the expected run
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_total++;
        close_out();
    end

    initial
    begin
        logic [15:0] words [5];
        int n;
        words = '{16'hffff, 16'h0001, 16'h0002, 16'h0042, 16'h0134};
        seed = 32'd89553;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        word_19 = 16'h0;
        ack_delay = 8'd20;
        err_total = 0;
        tests_run = 0;
        for (int i = 0; i < 11; i++)
        begin
            // corner words first, then random words; the latency is random on every pass
            word_19 <= (i < 5) ? words[i] : 16'(xorshift() >> 8);
            ack_delay <= 8'd20 + 8'(xorshift() & 32'h1f);
            presetn <= 1'b0;
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            apb(1'b1, 8'h10, 32'h3);
            apb(1'b0, 8'h08, 32'h0);
            chk("before load", 32'h0, rd);
            apb(1'b0, 8'h14, 32'h0);
            chk("status early", 32'h0, rd);
            chk("request", 32'h113, {23'h0, ee_request});
            n = 0;
            while (load_done !== 1'b1 && n < 100)
            begin
                @(posedge pclk);
                n++;
            end
            chk("load done", 32'h1, {31'h0, load_done});
            chk("request done", 32'h0, {31'h0, ee_request.valid});
            exp = ref_media(int'(word_19));
            chk("port", {16'h0, exp}, {16'h0, media_capability});
            apb(1'b0, 8'h08, 32'h0);
            chk("media", {16'h0, exp}, rd);
            chk("t4 bit", 32'h0, {31'h0, rd[0]});
            chk("unused", 32'h0, rd & 32'hffff_ffb0);
            apb(1'b1, 8'h08, xorshift());
            chk("write err", 32'h0, {31'h0, err});
            // a window write without the low strobe must not move the window
            pstrb <= 4'he;
            apb(1'b1, 8'h10, 32'h0);
            pstrb <= 4'hf;
            apb(1'b0, 8'h08, 32'h0);
            chk("after write", {16'h0, exp}, rd);
            chk("after write err", 32'h0, {31'h0, err});
            apb(1'b1, 8'h14, xorshift());
            chk("status write err", 32'h0, {31'h0, err});
            apb(1'b0, 8'h14, 32'h0);
            chk("status", 32'h1, rd);
            apb(1'b0, 8'h09, 32'h0);
            chk("misaligned err", 32'h1, {31'h0, err});
            chk("misaligned data", 32'h0, rd);
            apb(1'b0, 8'h20, 32'h0);
            chk("unmapped err", 32'h1, {31'h0, err});
            apb(1'b1, 8'h10, 32'h0);
            apb(1'b0, 8'h08, 32'h0);
            chk("other window", 32'h1, {31'h0, err});
            chk("refused data", 32'h0, rd);
        end
        close_out();
    end
endmodule

`default_nettype wire

// ### rtl/media_capability_register.sv
/*
 * Media capability register behind an APB slave, with the window select
 * and a load status word. The capability word is fetched from the
 * configuration eeprom after reset by media_word_loader.
 * Assumes one clock pclk at 100 MHz and an APB master per the protocol.
 */
// Register access over APB was chosen for this implementation.
// Behaviour
// - after reset the register is loaded from eeprom word 19.
// - reset clears every bit before the eeprom word arrives.
// - register is 16 bits, read-only, window 3 offset 8.
// - bit 0 reports a 100BASE-T4 phy reachable over the mii.
// - bit 0 is not implemented and always reads zero.
// - bit 1 reports a 100BASE-TX phy on the internal 100BASE-X path.
// - tx phy over mii means bit 1 reads zero and bit 6 one.
// - bit 2 reports a 100BASE-FX phy on the board.
// - bit 3 reports a 10BASE-T encoder/decoder and transceiver.
// - coax bit 4, aui bit 5 and 10BASE-FL bit 8 read zero.
// - bit 6 reports an external phy behind the mii.
`timescale 1ns/1ps
`default_nettype none

module media_capability_register
    import media_pkg::*;
#(
    parameter int unsigned ADDR_WIDTH = 8
)
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // configuration eeprom reader
    output var  ee_request_type        ee_request,
    input  wire ee_answer_type         ee_answer,
    // capability word for the media logic
    output var  media_bits_type        media_capability,
    output logic                       load_done
);

    // loaded word from the eeprom fetch
    logic        word_valid;
    logic [15:0] word;

    // window select, software writable
    logic [2:0] window_select;

    media_word_loader loader (
        .pclk       (pclk),
        .presetn    (presetn),
        .ee_request (ee_request),
        .ee_answer  (ee_answer),
        .word_valid (word_valid),
        .word       (word)
    );

    // clean the eeprom word: unbuilt media and reserved bits read zero
    media_bits_type raw_word;
    media_bits_type next_media;

    assign raw_word = media_bits_type'(word & MEDIA_IMPL_MASK);

    always_comb
    begin
        next_media = raw_word;
        next_media.t4_phy_present = 1'b0;
        // a phy behind the mii takes precedence over the internal path
        if (raw_word.external_phy_present)
            next_media.tx_internal_phy_present = 1'b0;
    end

    // apb phase decode
    wire setup_phase  = psel && !penable;
    wire access_phase = psel && penable;
    wire in_window    = (paddr <= ADDR_WIDTH'(WINDOW_SPACE_TOP));
    wire hit_media    = (paddr == ADDR_WIDTH'(MEDIA_OFFSET))
                        && (window_select == MEDIA_WINDOW);
    wire hit_window   = (paddr == ADDR_WIDTH'(WINDOW_SEL_OFFSET));
    wire hit_status   = (paddr == ADDR_WIDTH'(LOAD_STATUS_OFFSET));
    wire hit_any      = hit_media || hit_window || hit_status;
    wire misaligned   = (paddr[1:0] != 2'h0);

    // media word is read-only: writes to it are dropped, not refused
    wire refuse       = misaligned || !hit_any;
    wire write_window = access_phase && pwrite && hit_window
                        && !misaligned && pstrb[0];

    // read data as chosen in the setup cycle
    logic [31:0] next_rdata;

    assign next_rdata = hit_media  ? {16'h0000, media_capability}
                      : hit_window ? {29'h0, window_select}
                      : hit_status ? {31'h0, load_done}
                      : 32'h0000_0000;

    // zero wait states; the answer is ready in the access cycle
    assign pready = 1'b1;

    // read path registered at setup so prdata comes from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata  <= (pwrite || refuse) ? 32'h0000_0000 : next_rdata;
            pslverr <= refuse;
        end
        else if (!psel)
        begin
            pslverr <= 1'b0;
        end
    end

    // window select steers which register answers in the window space
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            window_select <= WINDOW_RESET;
        else if (write_window)
            window_select <= pwdata[2:0];
    end

    // capability word: cleared at reset, filled once from the eeprom
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            media_capability <= media_bits_type'(MEDIA_RESET);
            load_done        <= 1'b0;
        end
        else if (word_valid)
        begin
            media_capability <= next_media;
            load_done        <= 1'b1;
        end
    end

    // until the fetch completes the register shows all zeros
    a_clear_until_load: assert property (@(posedge pclk) disable iff (!presetn)
        !load_done |-> media_capability == media_bits_type'(MEDIA_RESET))
        else $error("capability word not clear before load");

    // the loaded fx, 10BASE-T and mii bits match the eeprom word, one cycle later
    a_load_value: assert property (@(posedge pclk) disable iff (!presetn)
        word_valid ##1 1'b1 |-> load_done
            && media_capability.fiber_100_phy_present
               == $past(word[2])
            && media_capability.twisted_pair_10_present
               == $past(word[3])
            && media_capability.external_phy_present
               == $past(word[6]))
        else $error("capability word differs from eeprom word");

    // internal tx bit follows the eeprom unless an mii phy is present
    a_tx_path_load: assert property (@(posedge pclk) disable iff (!presetn)
        word_valid |=> media_capability.tx_internal_phy_present
            == ($past(word[1]) && !$past(word[6])))
        else $error("internal tx bit loaded wrongly");

    // t4 bit never set on this board
    a_t4_zero: assert property (@(posedge pclk) disable iff (!presetn)
        media_capability.t4_phy_present == 1'b0)
        else $error("t4 capability bit set");

    // unbuilt media bits stay zero
    a_unbuilt_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !media_capability.thin_coax_present
        && !media_capability.attachment_unit_port_present
        && !media_capability.fiber_10_present)
        else $error("unbuilt media bit set");

    // reserved bits stay zero
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        media_capability.reserved_7 == 1'b0
        && media_capability.reserved_hi == 7'h00)
        else $error("reserved capability bit set");

    // mii phy and internal tx path never reported together
    a_mii_excludes_tx: assert property (@(posedge pclk) disable iff (!presetn)
        media_capability.external_phy_present
        |-> !media_capability.tx_internal_phy_present)
        else $error("internal tx bit set with mii phy");

    // a write into the media word leaves it unchanged
    a_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && hit_media && !word_valid
        |=> $stable(media_capability))
        else $error("write changed the capability word");

    // a read of window 3 offset 8 returns the word in the low half
    a_read_media: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit_media && !misaligned
        ##1 access_phase
        |-> prdata == {16'h0000, $past(media_capability)} && !pslverr)
        else $error("media read returned wrong data");

    // offset 8 in any other window is unmapped and errors
    a_other_window_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && paddr == ADDR_WIDTH'(MEDIA_OFFSET)
        && window_select != MEDIA_WINDOW
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("offset 8 outside window 3 not refused");

    // outside the window space only the two own words answer
    a_window_bound: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !in_window && !hit_window && !hit_status
        |=> pslverr)
        else $error("address outside window space not refused");

    // unmapped addresses error and read as zero
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !hit_any
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused");

    // a misaligned address is refused whatever it points at
    a_misaligned_err: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && misaligned
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("misaligned address not refused");

    // writes never leave read data behind on the bus
    a_write_no_data: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && pwrite
        |=> prdata == 32'h0000_0000)
        else $error("write cycle returned read data");

    // an error never outlives its transfer
    a_idle_no_error: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pslverr)
        else $error("error flag held while idle");

    // window select takes the written low bits
    a_window_write: assert property (@(posedge pclk) disable iff (!presetn)
        write_window
        |=> window_select == $past(pwdata[2:0]))
        else $error("window select not written");

    // without the low strobe the window select keeps its value
    a_strobe_gate: assert property (@(posedge pclk) disable iff (!presetn)
        access_phase && pwrite && hit_window && !pstrb[0]
        |=> $stable(window_select))
        else $error("window select written without strobe");

    // status read reports the load flag in bit 0
    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && hit_status ##1 access_phase
        |-> prdata == {31'h0, $past(load_done)} && !pslverr)
        else $error("status read returned wrong data");

    // the load flag holds until the next reset
    a_load_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        load_done |=> load_done)
        else $error("load flag dropped without reset");

    // the load flag only rises after a fetched word
    a_load_follows_word: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(load_done) |-> $past(word_valid))
        else $error("load flag rose without eeprom word");

    // no eeprom request remains once the word is in
    a_request_until_load: assert property (@(posedge pclk) disable iff (!presetn)
        ee_request.valid |-> !load_done)
        else $error("eeprom request after load");

    // once loaded the word never changes until reset
    a_hold_after_load: assert property (@(posedge pclk) disable iff (!presetn)
        load_done
        |=> $stable(media_capability))
        else $error("capability word changed after load");

    // fiber 100 bit is taken straight from the eeprom word
    a_fx_bit: assert property (@(posedge pclk) disable iff (!presetn)
        word_valid
        |=> media_capability.fiber_100_phy_present == $past(word[2]))
        else $error("fiber 100 bit loaded wrongly");

    // twisted pair 10 bit is taken straight from the eeprom word
    a_tp_bit: assert property (@(posedge pclk) disable iff (!presetn)
        word_valid
        |=> media_capability.twisted_pair_10_present == $past(word[3]))
        else $error("twisted pair 10 bit loaded wrongly");

endmodule

`default_nettype wire

// ### rtl/media_pkg.sv
/*
 * Shared constants and types for the media capability register block:
 * APB offsets, window selection, EEPROM word address, field layout and
 * the loader state encoding.
 * Assumes a 32-bit APB with byte addresses and 16-bit EEPROM words.
 */
package media_pkg;

    // apb byte offsets; media word lives inside the window space
    localparam logic [7:0] MEDIA_OFFSET       = 8'h08;
    localparam logic [7:0] WINDOW_SEL_OFFSET  = 8'h10;
    localparam logic [7:0] LOAD_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] WINDOW_SPACE_TOP   = 8'h0f;

    // window that exposes the media word, and window after reset
    localparam logic [2:0] MEDIA_WINDOW = 3'h3;
    localparam logic [2:0] WINDOW_RESET = 3'h0;

    // eeprom word holding the capability bits (decimal 19)
    localparam logic [7:0] EE_MEDIA_WORD = 8'h13;

    // register value after reset, and bits the board may report
    localparam logic [15:0] MEDIA_RESET     = 16'h0000;
    localparam logic [15:0] MEDIA_IMPL_MASK = 16'h004e;

    // field layout of the media capability word
    typedef struct packed {
        logic [6:0] reserved_hi;
        logic       fiber_10_present;
        logic       reserved_7;
        logic       external_phy_present;
        logic       attachment_unit_port_present;
        logic       thin_coax_present;
        logic       twisted_pair_10_present;
        logic       fiber_100_phy_present;
        logic       tx_internal_phy_present;
        logic       t4_phy_present;
    } media_bits_type;

    // word request to the configuration eeprom reader
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
    } ee_request_type;

    // answer from the eeprom reader
    typedef struct packed {
        logic        ack;
        logic [15:0] data;
    } ee_answer_type;

    // loader sequence, one-hot
    typedef enum logic [2:0] {
        LOAD_IDLE = 3'b001,
        LOAD_WAIT = 3'b010,
        LOAD_DONE = 3'b100
    } load_state_type;

endpackage

// ### rtl/media_word_loader.sv
/*
 * Fetches the media capability word from the configuration eeprom once
 * after every reset and hands it on as a one-cycle valid pulse.
 * Assumes the eeprom reader holds its ack for one cycle per request.
 */
`timescale 1ns/1ps
`default_nettype none

module media_word_loader
    import media_pkg::*;
(
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // eeprom reader
    output var  ee_request_type ee_request,
    input  wire ee_answer_type  ee_answer,
    // loaded word
    output logic                word_valid,
    output logic [15:0]         word
);

    load_state_type state;
    load_state_type next_state;

    // one request per reset; done is a sink until the next reset
    always_comb
    begin
        next_state = state;
        unique case (state)
            LOAD_IDLE: next_state = LOAD_WAIT;
            LOAD_WAIT: if (ee_answer.ack) next_state = LOAD_DONE;
            LOAD_DONE: next_state = LOAD_DONE;
            default:   next_state = LOAD_IDLE;
        endcase
    end

    // request is a level held while waiting
    assign ee_request.valid = (state == LOAD_WAIT);
    assign ee_request.addr  = EE_MEDIA_WORD;

    // state and captured word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= LOAD_IDLE;
            word_valid <= 1'b0;
            word       <= MEDIA_RESET;
        end
        else
        begin
            state      <= next_state;
            word_valid <= (state == LOAD_WAIT) && ee_answer.ack;
            if ((state == LOAD_WAIT) && ee_answer.ack)
                word <= ee_answer.data;
        end
    end

    // fetch only the capability word
    a_word_address: assert property (@(posedge pclk) disable iff (!presetn)
        ee_request.valid |-> ee_request.addr == EE_MEDIA_WORD)
        else $error("eeprom request not at capability word");

    // remembers a completed load so that a second one is caught
    logic loaded_once;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            loaded_once <= 1'b0;
        else if (word_valid)
            loaded_once <= 1'b1;
    end

    // a load happens once per reset
    a_single_load: assert property (@(posedge pclk) disable iff (!presetn)
        word_valid |-> !loaded_once)
        else $error("capability word loaded twice");

endmodule

`default_nettype wire
